// *** codec_consts.svh ***
// Timing constants and reset values for the codec serial interface
`ifndef CODEC_CONSTS_SVH
`define CODEC_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define POWERUP_HOLD_US 500
`define POWERUP_HOLD_CYC ((`POWERUP_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define CLOCK_LOSS_US 20
`define CLOCK_LOSS_CYC ((`CLOCK_LOSS_US * 1000) / `CLK_PERIOD_NS)
`define POWER_DOWN_US 10
`define POWER_DOWN_CYC ((`POWER_DOWN_US * 1000) / `CLK_PERIOD_NS)
`define STANDBY_MS 300
`define STANDBY_CYC ((`STANDBY_MS * 1000000) / `CLK_PERIOD_NS)
`define PCM_BITS 8
`define SIG_FRAME_MIN_MCLK 2
`define SAMPLE_RESET 8'hFF
`endif

// *** codec_pkg.sv ***
// Types shared by the codec serial interface
package codec_pkg;
   typedef enum logic {
      TIMING_FIXED,
      TIMING_VARIABLE
   } timing_mode_t;
   typedef struct packed {
      logic [7:0] word;
      logic signalling;
   } pcm_frame_t;
endpackage

// *** edge_sync.sv ***
// Two-flop synchroniser with rise and fall pulses
`timescale 1ns/1ps
module edge_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic async_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic prev;
   // ***************
   // Synchroniser
   // ***************
   // First stage read only by second stage to avoid metastable fan-out
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= 1'b0;
         level <= 1'b0;
      end else begin
         meta <= async_in;
         level <= meta;
      end
   end
   // Edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev <= 1'b0;
      end else begin
         prev <= level;
      end
   end
   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule

// *** hold_timer.sv ***
// Saturating watchdog: flags when a condition lasts LIMIT cycles
`timescale 1ns/1ps
module hold_timer #(
   parameter int LIMIT = 2000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   output logic expired
);
   logic [31:0] count;
   // Counts while run holds, restarts when it drops
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         count <= 32'h00000000;
      end else if (count < 32'(LIMIT)) begin
         count <= count + 32'h00000001;
      end
   end
   assign expired = run && (count >= 32'(LIMIT));
endmodule

// *** pcm_codec_serial_interface.sv ***
// Serial PCM side of a single-channel voice codec
`timescale 1ns/1ps
`include "codec_consts.svh"
module pcm_codec_serial_interface #(
   parameter int POWERUP_CYCLES = `POWERUP_HOLD_CYC,
   parameter int CLOCK_LOSS_CYCLES = `CLOCK_LOSS_CYC,
   parameter int POWER_DOWN_CYCLES = `POWER_DOWN_CYC,
   parameter int STANDBY_CYCLES = `STANDBY_CYC,
   parameter int MODE_LOSS_CYCLES = `CLOCK_LOSS_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Codec pins
   input wire logic power_down_n,
   input wire logic tx_master_clock,
   input wire logic rx_master_clock,
   input wire logic tx_bit_clock,
   input wire logic rx_bit_clock_or_mode_select,
   input wire logic tx_frame_sync,
   input wire logic rx_frame_sync,
   input wire logic tx_signalling_in,
   input wire logic pcm_in,
   output logic pcm_out,
   output logic pcm_out_oe,
   output logic tx_timeslot_active_n,
   output logic tx_timeslot_active_oe,
   output logic rx_signalling_out,
   output logic rx_signalling_oe
);

   localparam logic [31:0] TX_SAMPLE_ADDR = 32'h00000000;
   localparam logic [31:0] RX_SAMPLE_ADDR = 32'h00000004;
   localparam logic [31:0] STATUS_ADDR = 32'h00000008;

   // ***************
   // Pin synchronisers
   // ***************
   logic txm_l, txm_r, txm_f;
   logic rxm_l, rxm_r, rxm_f;
   logic txb_l, txb_r, txb_f;
   logic rxb_l, rxb_r, rxb_f;
   logic fsx_l, fsx_r, fsx_f;
   logic fsr_l, fsr_r, fsr_f;
   logic pdn_l, tx_signalling_in_l, pcmi_l;
   edge_sync sync_txm (.aclk(aclk), .aresetn(aresetn), .async_in(tx_master_clock),
      .level(txm_l), .rise(txm_r), .fall(txm_f));
   edge_sync sync_rxm (.aclk(aclk), .aresetn(aresetn), .async_in(rx_master_clock),
      .level(rxm_l), .rise(rxm_r), .fall(rxm_f));
   edge_sync sync_txb (.aclk(aclk), .aresetn(aresetn), .async_in(tx_bit_clock),
      .level(txb_l), .rise(txb_r), .fall(txb_f));
   edge_sync sync_rxb (.aclk(aclk), .aresetn(aresetn),
      .async_in(rx_bit_clock_or_mode_select), .level(rxb_l), .rise(rxb_r), .fall(rxb_f));
   edge_sync sync_fsx (.aclk(aclk), .aresetn(aresetn), .async_in(tx_frame_sync),
      .level(fsx_l), .rise(fsx_r), .fall(fsx_f));
   edge_sync sync_fsr (.aclk(aclk), .aresetn(aresetn), .async_in(rx_frame_sync),
      .level(fsr_l), .rise(fsr_r), .fall(fsr_f));
   edge_sync sync_pdn (.aclk(aclk), .aresetn(aresetn), .async_in(power_down_n),
      .level(pdn_l), .rise(), .fall());
   edge_sync sync_tx_signalling_in (.aclk(aclk), .aresetn(aresetn), .async_in(tx_signalling_in),
      .level(tx_signalling_in_l), .rise(), .fall());
   edge_sync sync_pcmi (.aclk(aclk), .aresetn(aresetn), .async_in(pcm_in),
      .level(pcmi_l), .rise(), .fall());

   // ***************
   // Watchdogs
   // ***************
   logic powered_up, txm_lost, rxm_lost, rxb_still, pd_done;
   logic stby_all, stby_tx, stby_rx;
   logic powering_up;
   logic txm_run, rxm_run, rxb_run;
   assign powering_up = 1'b1;
   hold_timer #(.LIMIT(POWERUP_CYCLES)) t_pwr (.aclk(aclk), .aresetn(aresetn),
      .run(powering_up), .expired(powered_up));
   assign txm_run = !txm_r && !txm_f;
   assign rxm_run = !rxm_r && !rxm_f;
   assign rxb_run = !rxb_r && !rxb_f;
   hold_timer #(.LIMIT(CLOCK_LOSS_CYCLES)) t_txm (.aclk(aclk), .aresetn(aresetn),
      .run(txm_run), .expired(txm_lost));
   hold_timer #(.LIMIT(CLOCK_LOSS_CYCLES)) t_rxm (.aclk(aclk), .aresetn(aresetn),
      .run(rxm_run), .expired(rxm_lost));
   hold_timer #(.LIMIT(MODE_LOSS_CYCLES)) t_rxb (.aclk(aclk), .aresetn(aresetn),
      .run(rxb_run && !rxb_l), .expired(rxb_still));
   hold_timer #(.LIMIT(POWER_DOWN_CYCLES)) t_pd (.aclk(aclk), .aresetn(aresetn),
      .run(!pdn_l), .expired(pd_done));
   hold_timer #(.LIMIT(STANDBY_CYCLES)) t_sa (.aclk(aclk), .aresetn(aresetn),
      .run(!fsx_l && !fsr_l), .expired(stby_all));
   hold_timer #(.LIMIT(STANDBY_CYCLES)) t_sx (.aclk(aclk), .aresetn(aresetn),
      .run(!fsx_l), .expired(stby_tx));
   hold_timer #(.LIMIT(STANDBY_CYCLES)) t_sr (.aclk(aclk), .aresetn(aresetn),
      .run(!fsr_l), .expired(stby_rx));

   // Bit clock pin held low (tied to the negative rail) selects fixed timing
   codec_pkg::timing_mode_t mode;
   assign mode = rxb_still ? codec_pkg::TIMING_FIXED : codec_pkg::TIMING_VARIABLE;

   logic pd_active;
   assign pd_active = !pdn_l;

   // ***************
   // Transmit side
   // ***************
   logic [7:0] tx_sample;
   codec_pkg::pcm_frame_t tx_frame;
   logic [3:0] tx_bit;
   logic tx_busy;
   logic [2:0] fsx_len;
   logic tx_shift_edge;
   logic tx_blocked;
   logic [7:0] tx_slots;
   // Shift edge chosen by timing mode
   assign tx_shift_edge = (mode == codec_pkg::TIMING_FIXED) ? txm_r : txb_r;
   assign tx_blocked = !powered_up || txm_lost || pd_active || stby_all || stby_tx;

   // Sync width in falling master edges, half a period clear of the sync's own edges
   always_ff @(posedge aclk) begin
      if (!aresetn || fsx_r) begin
         fsx_len <= 3'h0;
      end else if (fsx_l && txm_f && fsx_len != 3'h7) begin
         fsx_len <= fsx_len + 3'h1;
      end
   end

   // Slot sequencer; LSB substitution is decided once the sync width is known
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_frame <= '0;
         tx_bit <= 4'h0;
         tx_busy <= 1'b0;
         tx_slots <= 8'h00;
      end else if (tx_blocked) begin
         tx_busy <= 1'b0;
         tx_bit <= 4'h0;
      end else if (fsx_r) begin
         tx_frame.word <= tx_sample;
         tx_frame.signalling <= 1'b0;
         tx_busy <= 1'b1;
         tx_bit <= 4'h0;
      end else if (tx_busy && tx_shift_edge) begin
         if (tx_bit == 4'(`PCM_BITS - 1)) begin
            tx_slots <= tx_slots + 8'h01;
            // Repeat while sync stays high in variable mode
            tx_busy <= (mode == codec_pkg::TIMING_VARIABLE) && fsx_l;
            tx_bit <= 4'h0;
         end else begin
            tx_bit <= tx_bit + 4'h1;
         end
      end else if (tx_busy && mode == codec_pkg::TIMING_VARIABLE && !fsx_l) begin
         tx_busy <= 1'b0;
         tx_bit <= 4'h0;
      end
      if (!tx_blocked && fsx_f && mode == codec_pkg::TIMING_FIXED
            && fsx_len >= 3'(`SIG_FRAME_MIN_MCLK)) begin
         tx_frame.signalling <= 1'b1;
      end
   end

   // Serial data from flops, MSB first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pcm_out <= 1'b0;
      end else if (tx_busy && tx_bit == 4'(`PCM_BITS - 1) && tx_frame.signalling) begin
         pcm_out <= tx_signalling_in_l;
      end else begin
         pcm_out <= tx_frame.word[3'(`PCM_BITS - 1) - tx_bit[2:0]];
      end
   end
   assign pcm_out_oe = tx_busy && !tx_blocked;
   assign tx_timeslot_active_n = !(tx_busy && !tx_blocked);
   assign tx_timeslot_active_oe = !tx_blocked;

   // ***************
   // Receive side
   // ***************
   logic [7:0] rx_shift;
   logic [7:0] rx_sample;
   logic [3:0] rx_bit;
   logic rx_busy;
   logic [2:0] fsr_len;
   logic rx_sig_frame;
   logic rx_sample_edge;
   logic rx_sig_q;
   logic rx_blocked;
   logic [7:0] rx_words;
   assign rx_sample_edge = (mode == codec_pkg::TIMING_FIXED) ? rxm_f : rxb_f;
   assign rx_blocked = pd_active || stby_all || stby_rx || rxm_lost;

   always_ff @(posedge aclk) begin
      if (!aresetn || fsr_r) begin
         fsr_len <= 3'h0;
      end else if (fsr_l && rxm_f && fsr_len != 3'h7) begin
         fsr_len <= fsr_len + 3'h1;
      end
   end

   // Capture word MSB first on the chosen falling edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_shift <= 8'h00;
         rx_sample <= `SAMPLE_RESET;
         rx_bit <= 4'h0;
         rx_busy <= 1'b0;
         rx_sig_frame <= 1'b0;
         rx_words <= 8'h00;
      end else if (rx_blocked) begin
         rx_busy <= 1'b0;
         rx_bit <= 4'h0;
      end else if (fsr_r) begin
         rx_busy <= 1'b1;
         rx_bit <= 4'h0;
         rx_sig_frame <= 1'b0;
      end else begin
         if (fsr_f && mode == codec_pkg::TIMING_FIXED
               && fsr_len >= 3'(`SIG_FRAME_MIN_MCLK)) begin
            rx_sig_frame <= 1'b1;
         end
         if (rx_busy && rx_sample_edge && (mode == codec_pkg::TIMING_FIXED || fsr_l)) begin
            rx_shift <= {rx_shift[6:0], pcmi_l};
            if (rx_bit == 4'(`PCM_BITS - 1)) begin
               rx_busy <= 1'b0;
               rx_words <= rx_words + 8'h01;
               // Signalling frame keeps only seven bits for decode
               rx_sample <= rx_sig_frame ? {rx_shift[6:0], 1'b0}
                                         : {rx_shift[6:0], pcmi_l};
            end else begin
               rx_bit <= rx_bit + 4'h1;
            end
         end
      end
   end

   // Signalling output stays low until a signalling frame lands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sig_q <= 1'b0;
      end else if (pd_done || stby_all || rxm_lost) begin
         rx_sig_q <= 1'b0;
      end else if (!rx_blocked && rx_busy && rx_sample_edge && rx_sig_frame
            && rx_bit == 4'(`PCM_BITS - 1)) begin
         rx_sig_q <= pcmi_l;
      end
   end
   assign rx_signalling_out = rx_sig_q;
   assign rx_signalling_oe = !(stby_rx && !stby_all);

   // ***************
   // AXI4-Lite slave
   // ***************
   logic aw_held, w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h00000000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         tx_sample <= `SAMPLE_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr[31:2] == TX_SAMPLE_ADDR[31:2]) begin
               if (w_strb[0]) begin
                  tx_sample <= w_data[7:0];
               end
               s_axi_bresp <= 2'h0;
            end else if (aw_addr[31:2] == RX_SAMPLE_ADDR[31:2]
                  || aw_addr[31:2] == STATUS_ADDR[31:2]) begin
               s_axi_bresp <= 2'h0;
            end else begin
               s_axi_bresp <= 2'h2;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read path; status exposes mode, watchdog state and word counts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         if (s_axi_araddr[31:2] == TX_SAMPLE_ADDR[31:2]) begin
            s_axi_rdata <= {24'h000000, tx_sample};
         end else if (s_axi_araddr[31:2] == RX_SAMPLE_ADDR[31:2]) begin
            s_axi_rdata <= {24'h000000, rx_sample};
         end else if (s_axi_araddr[31:2] == STATUS_ADDR[31:2]) begin
            s_axi_rdata <= {rx_words, tx_slots, 7'h00, rx_sig_q, rxm_lost, txm_lost,
               stby_rx, stby_tx, stby_all, pd_active, powered_up,
               (mode == codec_pkg::TIMING_VARIABLE)};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// *** pcm_codec_sva.sv ***
// Concurrent checks on the codec serial pins
`timescale 1ns/1ps
module pcm_codec_sva #(
   parameter int POWERUP_CYCLES = 50,
   parameter int CLOCK_LOSS_CYCLES = 40,
   parameter int POWER_DOWN_CYCLES = 20,
   parameter int STANDBY_CYCLES = 600
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_down_n,
   input wire logic tx_master_clock,
   input wire logic rx_master_clock,
   input wire logic tx_frame_sync,
   input wire logic rx_frame_sync,
   input wire logic pcm_out_oe,
   input wire logic tx_timeslot_active_n,
   input wire logic tx_timeslot_active_oe,
   input wire logic rx_signalling_out,
   input wire logic rx_signalling_oe
);
   localparam int PD_MAX = POWER_DOWN_CYCLES + 4;
   logic [15:0] up_cnt, txc_idle, rxc_idle, tx_low, rx_low;
   logic txc_last, rxc_last;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Saturating, so a long idle stretch never wraps back under a limit
   function automatic logic [15:0] bump(input logic [15:0] c, input logic go);
      return go ? c + {15'h0000, c != 16'hFFFF} : 16'h0000;
   endfunction
   // ************************************
   // Helper counters
   // ************************************
   // Cycles since reset, since each clock moved, and each sync held low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_cnt <= 16'h0000;
         txc_idle <= 16'h0000;
         rxc_idle <= 16'h0000;
         tx_low <= 16'h0000;
         rx_low <= 16'h0000;
      end else begin
         up_cnt <= bump(up_cnt, 1'b1);
         txc_idle <= bump(txc_idle, tx_master_clock == txc_last);
         rxc_idle <= bump(rxc_idle, rx_master_clock == rxc_last);
         tx_low <= bump(tx_low, !tx_frame_sync);
         rx_low <= bump(rx_low, !rx_frame_sync);
      end
      txc_last <= tx_master_clock;
      rxc_last <= rx_master_clock;
   end
   // ************************************
   // Assertions
   // ************************************
   powerup_float_a: assert property (up_cnt < POWERUP_CYCLES - 1 |-> !pcm_out_oe && !tx_timeslot_active_oe)
      else $error("transmit outputs driven during power-up hold");
   powerup_sig_a: assert property (up_cnt < POWERUP_CYCLES - 1 |-> !rx_signalling_out)
      else $error("signalling output high during power-up hold");
   txclk_loss_a: assert property (txc_idle > CLOCK_LOSS_CYCLES + 4 |-> !pcm_out_oe)
      else $error("pcm output driven after transmit clock stopped");
   rxclk_loss_a: assert property (rxc_idle > CLOCK_LOSS_CYCLES + 4 |-> !rx_signalling_out)
      else $error("signalling output high after receive clock stopped");
   pdn_float_a: assert property (!power_down_n [*5] |-> !pcm_out_oe && !tx_timeslot_active_oe)
      else $error("transmit outputs driven in power-down");
   pdn_sig_a: assert property ($fell(power_down_n) |-> ##[1:PD_MAX] (!rx_signalling_out || power_down_n))
      else $error("signalling output not low in power-down");
   tx_standby_a: assert property (tx_low > STANDBY_CYCLES + 4 |-> !pcm_out_oe && !tx_timeslot_active_oe)
      else $error("transmit outputs driven in transmit standby");
   all_standby_a: assert property (tx_low > STANDBY_CYCLES + 4 && rx_low > STANDBY_CYCLES + 4 |-> !rx_signalling_out)
      else $error("signalling output high in full standby");
   rx_standby_a: assert property ((rx_low > STANDBY_CYCLES + 4 && tx_frame_sync) [*6] |-> !rx_signalling_oe)
      else $error("signalling output driven in receive standby");
   slot_flag_a: assert property (pcm_out_oe == (tx_timeslot_active_oe && !tx_timeslot_active_n))
      else $error("timeslot flag disagrees with pcm output enable");
endmodule
bind pcm_codec_serial_interface pcm_codec_sva #(.POWERUP_CYCLES(POWERUP_CYCLES),
   .CLOCK_LOSS_CYCLES(CLOCK_LOSS_CYCLES), .POWER_DOWN_CYCLES(POWER_DOWN_CYCLES),
   .STANDBY_CYCLES(STANDBY_CYCLES)) chk (.aclk, .aresetn, .power_down_n, .tx_master_clock,
   .rx_master_clock, .tx_frame_sync, .rx_frame_sync, .pcm_out_oe, .tx_timeslot_active_n,
   .tx_timeslot_active_oe, .rx_signalling_out, .rx_signalling_oe);

// *** pcm_link_model.sv ***
// Highway controller model: master clock, frame syncs and serial data
`timescale 1ns/1ps
module pcm_link_model (
   input wire logic clk_run,
   input wire logic hold_tx,
   input wire logic hold_rx,
   input wire logic pcm_out,
   output logic master_clock,
   output logic tx_frame_sync,
   output logic rx_frame_sync,
   output logic pcm_in
);
   logic sync;
   // Master clock of 125 ns, running only while clk_run is high so the bench can stop it
   initial begin
      master_clock = 1'b0;
      sync = 1'b0;
      pcm_in = 1'b1;
      forever begin
         #62.5;
         if (clk_run) master_clock = ~master_clock;
      end
   end
   // Holds let the bench park either sync high for standby cases
   assign tx_frame_sync = sync | hold_tx;
   assign rx_frame_sync = sync | hold_rx;
   // One frame: sync sig+1 periods long, data MSB first
   task automatic frame(input int sig, input logic [7:0] word, output logic [7:0] got);
      @(posedge master_clock);
      #5;
      sync = 1'b1;
      pcm_in = word[7];
      for (int i = 0; i < 8; i++) begin
         @(negedge master_clock);
         got[7 - i] = pcm_out;
         @(posedge master_clock);
         #5;
         if (i == sig) sync = 1'b0;
         pcm_in = (i < 7) ? word[6 - i] : ~word[0]; // Released line shows inverse
      end
   endtask
endmodule

// *** pcm_codec_serial_interface_bench.sv ***
// Self-checking bench for the codec serial interface
`timescale 1ns/1ps
module pcm_codec_serial_interface_bench;
   localparam int STANDBY = 600;
   localparam int LIMIT = 20000;
   logic aclk = 1'b0, aresetn = 1'b0, power_down_n = 1'b0, tx_signalling_in = 1'b0;
   logic clk_run = 1'b1, hold_tx = 1'b0, hold_rx = 1'b0, vmode = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h00000000, s_axi_wdata = 32'h00000000;
   logic [31:0] s_axi_araddr = 32'h00000000, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic mclk, tx_frame_sync, rx_frame_sync, pcm_in, pcm_out, pcm_out_oe;
   logic tx_timeslot_active_n, tx_timeslot_active_oe, rx_signalling_out, rx_signalling_oe;
   logic [7:0] got;
   int failures = 0, compares = 0, cycles = 0;
   pcm_codec_serial_interface #(.POWERUP_CYCLES(50), .CLOCK_LOSS_CYCLES(40),
      .POWER_DOWN_CYCLES(20), .STANDBY_CYCLES(STANDBY), .MODE_LOSS_CYCLES(40)) dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .power_down_n, .tx_master_clock(mclk),
      .rx_master_clock(mclk), .tx_bit_clock(mclk & vmode),
      .rx_bit_clock_or_mode_select(mclk & vmode),
      .tx_frame_sync, .rx_frame_sync, .tx_signalling_in, .pcm_in, .pcm_out, .pcm_out_oe,
      .tx_timeslot_active_n, .tx_timeslot_active_oe, .rx_signalling_out, .rx_signalling_oe);
   pcm_link_model link (.clk_run, .hold_tx, .hold_rx, .pcm_out, .master_clock(mclk),
      .tx_frame_sync, .rx_frame_sync, .pcm_in);
   // ************************************
   // Clock, timeout and verdict
   // ************************************
   // 100 MHz system clock
   initial begin
      forever #5 aclk = ~aclk;
   end
   // A hang counts as a mismatch and still reaches the verdict
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         failures = failures + 1;
         conclude();
      end
   end
   task automatic conclude();
      if (failures == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ************************************
   // Register bus master
   // ************************************
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // ************************************
   // Scenarios
   // ************************************
   // Load a word, run one frame both ways, judge both words and the signalling pin
   task automatic run_frame(input int sig, input logic [7:0] tx, input logic [7:0] rx,
         input logic [7:0] etx, input logic [7:0] erx, input logic esig);
      axi_write(32'h00000000, {24'h000000, tx});
      link.frame(sig, rx, got);
      repeat (10) @(posedge aclk);
      axi_read(32'h00000004, rd, rr);
      check({24'h000000, got}, {24'h000000, etx});
      check({24'h000000, rd[7:0]}, {24'h000000, erx});
      check({31'h00000000, rx_signalling_out}, {31'h00000000, esig});
   endtask
   // Signalling frame that leaves the signalling pin high
   task automatic arm();
      run_frame(1'b1, 8'h01, 8'h01, 8'h01, 8'h00, 1'b1);
   endtask
   task automatic test_regs();
      axi_read(32'h00000000, rd, rr);
      check({24'h000000, rd[7:0]}, 32'h000000FF);
      axi_read(32'h0000000C, rd, rr);
      check({30'h00000000, rr}, 32'h00000002);
      check(rd, 32'h00000000);
   endtask
   task automatic test_plain();
      run_frame(1'b0, 8'hA5, 8'h3C, 8'hA5, 8'h3C, 1'b0);
      run_frame(1'b0, 8'h3C, 8'hC3, 8'h3C, 8'hC3, 1'b0);
   endtask
   // Signalling on both channels, then a plain frame must leave LSBs alone
   task automatic test_signalling();
      @(posedge aclk);
      tx_signalling_in <= 1'b1;
      run_frame(1'b1, 8'h5A, 8'h81, 8'h5B, 8'h80, 1'b1);
      @(posedge aclk);
      tx_signalling_in <= 1'b0;
      run_frame(1'b1, 8'h5B, 8'h7E, 8'h5A, 8'h7E, 1'b0);
      @(posedge aclk);
      tx_signalling_in <= 1'b1;
      arm();
      run_frame(1'b0, 8'h0F, 8'hF1, 8'h0F, 8'hF1, 1'b1);
   endtask
   // Variable rate: bit clocks follow the master clock, sync spans the whole slot
   task automatic test_variable();
      @(posedge aclk);
      vmode <= 1'b1;
      repeat (20) @(posedge aclk);
      // Signalling input still high: no LSB swap outside fixed rate
      run_frame(7, 8'hC6, 8'h39, 8'hC6, 8'h39, 1'b1);
      axi_read(32'h00000008, rd, rr);
      check({31'h00000000, rd[0]}, 32'h00000001);
      @(posedge aclk);
      vmode <= 1'b0;
      repeat (80) @(posedge aclk);
   endtask
   // Full, transmit-only and receive-only standby in turn
   task automatic test_standby();
      for (int k = 0; k < 3; k++) begin
         arm();
         @(posedge aclk);
         hold_tx <= (k == 2);
         hold_rx <= (k == 1);
         repeat (STANDBY + 40) @(posedge aclk);
         if (k != 2) check({31'h00000000, pcm_out_oe}, 32'h00000000);
         if (k == 0) check({31'h00000000, rx_signalling_out}, 32'h00000000);
         if (k == 2) check({31'h00000000, rx_signalling_oe}, 32'h00000000);
         hold_tx <= 1'b0;
         hold_rx <= 1'b0;
         repeat (80) @(posedge aclk);
      end
   endtask
   task automatic test_power_down();
      arm();
      @(posedge aclk);
      power_down_n <= 1'b0;
      repeat (40) @(posedge aclk);
      check({31'h00000000, pcm_out_oe}, 32'h00000000);
      check({31'h00000000, rx_signalling_out}, 32'h00000000);
      axi_read(32'h00000008, rd, rr);
      check({31'h00000000, rd[2]}, 32'h00000001);
      power_down_n <= 1'b1;
      repeat (80) @(posedge aclk);
      arm();
   endtask
   // Stopped master clock floats the slot and clears signalling
   task automatic test_clock_loss();
      arm();
      @(posedge aclk);
      clk_run <= 1'b0;
      repeat (80) @(posedge aclk);
      check({31'h00000000, pcm_out_oe}, 32'h00000000);
      check({31'h00000000, tx_timeslot_active_oe}, 32'h00000000);
      check({31'h00000000, rx_signalling_out}, 32'h00000000);
      clk_run <= 1'b1;
      repeat (80) @(posedge aclk);
      arm();
   endtask
   // Reset, then power-up order: clocks already run, power-down released, then frames
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      power_down_n <= 1'b1;
      repeat (80) @(posedge aclk);
      test_regs();
      test_plain();
      test_signalling();
      test_variable();
      test_standby();
      test_power_down();
      test_clock_loss();
      conclude();
   end
endmodule
